// file: include/tpa_pkg.sv
// constants, field positions and types of the timer/prescaler block
// assumes a 40 MHz clock, four clocks per instruction cycle (Q1..Q4)
// Notes on behaviour
// - overflow flag is sampled once per instruction cycle, at Q1
// - overflow event to handler entry takes four instruction cycles
// - clock output pin driven only in resistor-capacitor oscillator mode
// - prescaler moves between timer and watchdog by a config write
// - writing the timer count also clears prescaler when timer owns it
// - unimplemented bits of timer registers read as zero
// - watchdog clear resets watchdog and prescaler when watchdog owns it
// - flags set on their events regardless of any enable bit
// - any reset clears the global interrupt enable
package tpa_pkg;
  // ---------------------------------------------------------------
  // register indices (byte address is four times the index)
  // ---------------------------------------------------------------
  localparam logic [9:0] IDX_TIMER_COUNT = 10'h001;
  localparam logic [9:0] IDX_INTERRUPT_CONTROL = 10'h00B;
  localparam logic [9:0] IDX_INTERRUPT_CONTROL_ALT = 10'h08B;
  localparam logic [9:0] IDX_TIMER_PORT_CONFIG = 10'h081;
  localparam logic [9:0] IDX_PORT_A_DIRECTION = 10'h085;
  localparam logic [9:0] IDX_IRQ_STATUS = 10'h090;
  localparam logic [9:0] IDX_IRQ_MASK = 10'h091;
  localparam logic [9:0] IDX_WDT_CONTROL = 10'h092;
  localparam logic [9:0] IDX_WDT_STATE = 10'h093;
  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [7:0] RST_TIMER_COUNT = 8'h00;
  localparam logic [7:0] RST_INTERRUPT_CONTROL = 8'h00;
  localparam logic [7:0] RST_TIMER_PORT_CONFIG = 8'hFF;
  localparam logic [4:0] RST_PORT_A_DIRECTION = 5'h1F;
  localparam logic [2:0] RST_IRQ_MASK = 3'h0;
  localparam logic [3:0] RST_WDT_CONTROL = 4'h0;
  // ---------------------------------------------------------------
  // interrupt control fields
  // ---------------------------------------------------------------
  localparam int IC_GLOBAL_EN = 7;
  localparam int IC_TIMER_EN = 5;
  localparam int IC_EXT_EN = 4;
  localparam int IC_PORT_EN = 3;
  localparam int IC_TIMER_FLAG = 2;
  localparam int IC_EXT_FLAG = 1;
  localparam int IC_PORT_FLAG = 0;
  localparam logic [7:0] IC_IMPL_MASK = 8'hBF;
  // ---------------------------------------------------------------
  // configuration fields
  // ---------------------------------------------------------------
  localparam int CF_CLK_SOURCE = 5;
  localparam int CF_EDGE_SELECT = 4;
  localparam int CF_ASSIGN = 3;
  localparam int CF_RATE_LSB = 0;
  localparam int RATE_W = 3;
  // ---------------------------------------------------------------
  // own status, mask and watchdog control fields
  // ---------------------------------------------------------------
  localparam int ST_TIMER_OVF = 0;
  localparam int ST_WDT_TIMEOUT = 1;
  localparam int ST_HANDLER_ENTRY = 2;
  localparam int EVT_W = 3;
  localparam int WC_CLEAR = 0;
  localparam int WC_ENABLE = 1;
  localparam int WC_OSC_LSB = 2;
  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int CLOCK_HZ = 40_000_000;
  localparam int PHASES_PER_CYCLE = 4;
  localparam int INT_LATENCY_TCY = 4;
  localparam logic [2:0] INT_LAT_LAST = 3'(INT_LATENCY_TCY - 1);

  typedef enum logic [1:0] {
    OSC_LOW_POWER,
    OSC_CRYSTAL,
    OSC_HIGH_SPEED,
    OSC_RES_CAP
  } tpa_osc_t;

  typedef enum logic {
    ENTRY_IDLE,
    ENTRY_WAIT
  } tpa_entry_t;
endpackage

// file: include/tpa_pre_if.sv
// carrier between the top and the shared prescaler
// assumes a single clock domain; all signals are one-cycle pulses or levels
interface tpa_pre_if;
  logic timerTick;
  logic wdtTick;
  logic assignWdt;
  logic [2:0] rate;
  logic clear;
  logic timerOut;
  logic wdtOut;
  logic [7:0] count;

  modport owner (
    output timerTick, wdtTick, assignWdt, rate, clear,
    input timerOut, wdtOut, count
  );
  modport scaler (
    input timerTick, wdtTick, assignWdt, rate, clear,
    output timerOut, wdtOut, count
  );
endinterface

// file: verilog/tpa_phase_gen.sv
// quarter-phase generator: splits each instruction cycle into Q1..Q4
// assumes one clock, four clocks per instruction cycle
module tpa_phase_gen (
  input wire logic clock,
  input wire logic rst_n,
  output logic [1:0] phase,
  output logic q1Pulse,
  output logic q4Pulse
);
  import tpa_pkg::*;

  logic [1:0] phase_q;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      phase_q <= 2'h0;
    end else begin
      phase_q <= phase_q + 2'h1;
    end
  end

  assign phase = phase_q;
  assign q1Pulse = (phase_q == 2'h0);
  assign q4Pulse = (phase_q == 2'(PHASES_PER_CYCLE - 1));
endmodule

// file: verilog/tpa_prescaler.sv
// shared 8-bit prescaler, owned by either the timer or the watchdog
// assumes ticks are one-cycle pulses from the owner module
module tpa_prescaler (
  input wire logic clock,
  input wire logic rst_n,
  tpa_pre_if.scaler pre
);
  import tpa_pkg::*;

  logic [7:0] count_q;

  // true when the low n bits of the count are all ones
  function automatic logic lowOnes(input logic [7:0] c, input logic [3:0] n);
    logic [7:0] m;
    m = 8'((9'h001 << n) - 9'h001);
    return (c & m) == m;
  endfunction

  logic ownTick;

  assign ownTick = pre.assignWdt ? pre.wdtTick : pre.timerTick;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      count_q <= 8'h00;
    end else if (pre.clear) begin
      count_q <= 8'h00;
    end else if (ownTick) begin
      count_q <= count_q + 8'h01;
    end
  end

  // timer divides by 2^(rate+1); watchdog by 2^rate, so rate 0 passes
  assign pre.timerOut = pre.assignWdt ? pre.timerTick :
    (pre.timerTick && lowOnes(count_q, 4'({1'b0, pre.rate}) + 4'h1));
  assign pre.wdtOut = pre.assignWdt ?
    (pre.wdtTick && lowOnes(count_q, 4'({1'b0, pre.rate}))) : pre.wdtTick;
  assign pre.count = count_q;
endmodule

// file: verilog/tpa_top.sv
// timer counter with shared prescaler, watchdog and APB register file
// assumes APB master, synchronous event inputs, one 40 MHz clock
module tpa_top #(
  parameter int WDT_BASE_CYC = 256
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic extClockIn,
  input wire logic extIntEvent,
  input wire logic portChangeEvent,
  output logic clockOutPin,
  output logic clockOutEn,
  output logic [4:0] portADirection,
  output logic vectorEntry,
  output logic wdtTimeout,
  output logic irq
);
  import tpa_pkg::*;

  // ---------------------------------------------------------------
  // parameter checks
  // ---------------------------------------------------------------
  if (WDT_BASE_CYC < 1 || WDT_BASE_CYC > 65536) begin : gBadBase
    $error("WDT_BASE_CYC out of range");
  end

  // ---------------------------------------------------------------
  // register decode
  // ---------------------------------------------------------------
  logic [9:0] idx;
  logic aligned;
  logic setup;
  logic access;
  logic wrEn;
  logic mapped;

  function automatic logic isMapped(input logic [9:0] i);
    return i == IDX_TIMER_COUNT || i == IDX_INTERRUPT_CONTROL ||
      i == IDX_INTERRUPT_CONTROL_ALT || i == IDX_TIMER_PORT_CONFIG ||
      i == IDX_PORT_A_DIRECTION || i == IDX_IRQ_STATUS ||
      i == IDX_IRQ_MASK || i == IDX_WDT_CONTROL || i == IDX_WDT_STATE;
  endfunction

  function automatic logic hits(input logic [9:0] i, input logic [9:0] r);
    return i == r;
  endfunction

  assign idx = paddr[11:2];
  assign aligned = (paddr[1:0] == 2'h0);
  assign mapped = aligned && isMapped(idx);
  assign setup = psel && !penable;
  assign access = psel && penable;
  assign wrEn = access && pwrite && mapped;
  assign pready = 1'b1;
  assign pslverr = access && !mapped;

  logic wrTimer;
  logic wrIntCtl;
  logic wrConfig;
  logic wrPortDir;
  logic wrStatus;
  logic wrMask;
  logic wrWdtCtl;

  assign wrTimer = wrEn && hits(idx, IDX_TIMER_COUNT);
  assign wrIntCtl = wrEn && (hits(idx, IDX_INTERRUPT_CONTROL) ||
    hits(idx, IDX_INTERRUPT_CONTROL_ALT));
  assign wrConfig = wrEn && hits(idx, IDX_TIMER_PORT_CONFIG);
  assign wrPortDir = wrEn && hits(idx, IDX_PORT_A_DIRECTION);
  assign wrStatus = wrEn && hits(idx, IDX_IRQ_STATUS);
  assign wrMask = wrEn && hits(idx, IDX_IRQ_MASK);
  assign wrWdtCtl = wrEn && hits(idx, IDX_WDT_CONTROL);

  // ---------------------------------------------------------------
  // phases and prescaler
  // ---------------------------------------------------------------
  logic [1:0] phase;
  logic q1Pulse;
  logic q4Pulse;

  tpa_phase_gen uPhase (
    .clock(clock),
    .rst_n(rst_n),
    .phase(phase),
    .q1Pulse(q1Pulse),
    .q4Pulse(q4Pulse)
  );

  tpa_pre_if pre ();

  tpa_prescaler uPre (
    .clock(clock),
    .rst_n(rst_n),
    .pre(pre)
  );

  // ---------------------------------------------------------------
  // configuration and control registers
  // ---------------------------------------------------------------
  logic [7:0] config_q;
  logic [4:0] portDir_q;
  logic [EVT_W-1:0] mask_q;
  logic wdtEnable_q;
  logic [1:0] oscMode_q;
  logic wdtClear;

  // assignment changes on any config write
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      config_q <= RST_TIMER_PORT_CONFIG;
    end else if (wrConfig) begin
      config_q <= pwdata[7:0];
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      portDir_q <= RST_PORT_A_DIRECTION;
    end else if (wrPortDir) begin
      portDir_q <= pwdata[4:0];
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      mask_q <= RST_IRQ_MASK;
    end else if (wrMask) begin
      mask_q <= pwdata[EVT_W-1:0];
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      wdtEnable_q <= RST_WDT_CONTROL[WC_ENABLE];
      oscMode_q <= RST_WDT_CONTROL[WC_OSC_LSB +: 2];
    end else if (wrWdtCtl) begin
      wdtEnable_q <= pwdata[WC_ENABLE];
      oscMode_q <= pwdata[WC_OSC_LSB +: 2];
    end
  end

  // clear bit is a command; it is never stored
  assign wdtClear = wrWdtCtl && pwdata[WC_CLEAR];
  assign portADirection = portDir_q;

  // ---------------------------------------------------------------
  // tick sources and prescaler control
  // ---------------------------------------------------------------
  logic extPrev_q;
  logic extEdge;
  logic [15:0] baseCnt_q;
  logic baseTick;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      extPrev_q <= 1'b0;
    end else begin
      extPrev_q <= extClockIn;
    end
  end

  // edge select: zero counts rising, one counts falling
  assign extEdge = config_q[CF_EDGE_SELECT] ? (extPrev_q && !extClockIn) :
    (!extPrev_q && extClockIn);

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      baseCnt_q <= 16'h0000;
    end else if (baseTick) begin
      baseCnt_q <= 16'h0000;
    end else begin
      baseCnt_q <= baseCnt_q + 16'h0001;
    end
  end

  assign baseTick = (baseCnt_q == 16'(WDT_BASE_CYC - 1));

  assign pre.timerTick = config_q[CF_CLK_SOURCE] ? extEdge : q4Pulse;
  assign pre.wdtTick = baseTick && wdtEnable_q;
  assign pre.assignWdt = config_q[CF_ASSIGN];
  assign pre.rate = config_q[CF_RATE_LSB +: RATE_W];
  assign pre.clear = (wrTimer && !config_q[CF_ASSIGN]) ||
    (wdtClear && config_q[CF_ASSIGN]);

  // ---------------------------------------------------------------
  // timer count
  // ---------------------------------------------------------------
  logic [7:0] timer_q;
  logic timerOvf;

  // eight-bit up count, wrap flags overflow
  assign timerOvf = pre.timerOut && !wrTimer && (timer_q == 8'hFF);

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      timer_q <= RST_TIMER_COUNT;
    end else if (wrTimer) begin
      timer_q <= pwdata[7:0];
    end else if (pre.timerOut) begin
      timer_q <= timer_q + 8'h01;
    end
  end

  // ---------------------------------------------------------------
  // watchdog counter
  // ---------------------------------------------------------------
  logic [7:0] wdt_q;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      wdt_q <= 8'h00;
    end else if (wdtClear) begin
      wdt_q <= 8'h00;
    end else if (pre.wdtOut) begin
      wdt_q <= wdt_q + 8'h01;
    end
  end

  assign wdtTimeout = pre.wdtOut && !wdtClear && (wdt_q == 8'hFF);

  // ---------------------------------------------------------------
  // interrupt control register
  // ---------------------------------------------------------------
  logic [7:0] intCtl_q;
  logic [7:0] intCtlWr;
  logic entryFire;

  assign intCtlWr = wrIntCtl ? (pwdata[7:0] & IC_IMPL_MASK) : intCtl_q;

  // flags set whatever the enables; set beats a clear
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      intCtl_q <= RST_INTERRUPT_CONTROL;
    end else begin
      intCtl_q <= intCtlWr;
      intCtl_q[IC_TIMER_FLAG] <= intCtlWr[IC_TIMER_FLAG] || timerOvf;
      intCtl_q[IC_EXT_FLAG] <= intCtlWr[IC_EXT_FLAG] || extIntEvent;
      intCtl_q[IC_PORT_FLAG] <= intCtlWr[IC_PORT_FLAG] || portChangeEvent;
      // entry response drops the global enable
      intCtl_q[IC_GLOBAL_EN] <= intCtlWr[IC_GLOBAL_EN] && !entryFire;
    end
  end

  // ---------------------------------------------------------------
  // interrupt entry sequencing
  // ---------------------------------------------------------------
  tpa_entry_t entry_q;
  logic [2:0] latCnt_q;
  logic sampled;

  // flag looked at only in Q1
  assign sampled = q1Pulse && intCtl_q[IC_TIMER_FLAG] &&
    intCtl_q[IC_TIMER_EN] && intCtl_q[IC_GLOBAL_EN];
  // fires on the fourth Q1 after sampling
  assign entryFire = (entry_q == ENTRY_WAIT) && q1Pulse &&
    (latCnt_q == INT_LAT_LAST);

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      entry_q <= ENTRY_IDLE;
      latCnt_q <= 3'h0;
    end else begin
      case (entry_q)
        ENTRY_IDLE: begin
          latCnt_q <= 3'h0;
          if (sampled) begin
            entry_q <= ENTRY_WAIT;
          end
        end
        ENTRY_WAIT: begin
          if (entryFire) begin
            entry_q <= ENTRY_IDLE;
          end else if (q1Pulse) begin
            latCnt_q <= latCnt_q + 3'h1;
          end
        end
        default: begin
          entry_q <= ENTRY_IDLE;
        end
      endcase
    end
  end

  assign vectorEntry = entryFire;

  // ---------------------------------------------------------------
  // sticky status and interrupt output
  // ---------------------------------------------------------------
  logic [EVT_W-1:0] status_q;
  logic [EVT_W-1:0] evtSet;
  logic [EVT_W-1:0] evtClr;

  assign evtSet[ST_TIMER_OVF] = timerOvf;
  assign evtSet[ST_WDT_TIMEOUT] = wdtTimeout;
  assign evtSet[ST_HANDLER_ENTRY] = entryFire;
  assign evtClr = wrStatus ? pwdata[EVT_W-1:0] : '0;

  // set wins over a same-cycle write-one clear
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      status_q <= '0;
    end else begin
      status_q <= (status_q & ~evtClr) | evtSet;
    end
  end

  assign irq = |(status_q & mask_q);

  // ---------------------------------------------------------------
  // clock output pin
  // ---------------------------------------------------------------
  logic clock_output_pin_q;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      clock_output_pin_q <= 1'b0;
    end else begin
      // high across Q3 and Q4 of the next cycle position
      clock_output_pin_q <= (phase == 2'h1) || (phase == 2'h2);
    end
  end

  assign clockOutPin = clock_output_pin_q;
  assign clockOutEn = (tpa_osc_t'(oscMode_q) == OSC_RES_CAP);

  // ---------------------------------------------------------------
  // read data, captured in the setup phase
  // ---------------------------------------------------------------
  logic [31:0] rdMux;
  logic [31:0] prdata_q;

  always_comb begin
    rdMux = 32'h0000_0000;
    if (aligned) begin
      case (idx)
        IDX_TIMER_COUNT: rdMux = {24'h0, timer_q};
        IDX_INTERRUPT_CONTROL,
        IDX_INTERRUPT_CONTROL_ALT: rdMux = {24'h0, intCtl_q & IC_IMPL_MASK};
        IDX_TIMER_PORT_CONFIG: rdMux = {24'h0, config_q};
        IDX_PORT_A_DIRECTION: rdMux = {27'h0, portDir_q};
        IDX_IRQ_STATUS: rdMux = {29'h0, status_q};
        IDX_IRQ_MASK: rdMux = {29'h0, mask_q};
        IDX_WDT_CONTROL: rdMux = {28'h0, oscMode_q, wdtEnable_q, 1'b0};
        IDX_WDT_STATE: rdMux = {16'h0, pre.count, wdt_q};
        default: rdMux = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      prdata_q <= 32'h0000_0000;
    end else if (setup && !pwrite) begin
      prdata_q <= rdMux;
    end
  end

  assign prdata = prdata_q;
endmodule

// file: bench/tpa_props.sv
// concurrent checks on the ports of the timer/prescaler top
// assumes a single clock domain with rst_n as its only reset
module tpa_props #(
  parameter int WDT_BASE_CYC = 256
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic clockOutPin,
  input wire logic clockOutEn,
  input wire logic [4:0] portADirection,
  input wire logic vectorEntry,
  input wire logic wdtTimeout,
  input wire logic irq
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  // ---------------------------------------------------------------
  // bus side
  // ---------------------------------------------------------------
  pready_const_a: assert property (pready)
    else $error("ready dropped");
  err_in_access_a: assert property (pslverr |-> psel && penable)
    else $error("slave error outside access phase");
  err_data_zero_a: assert property (pslverr && !pwrite |-> prdata == 32'h0)
    else $error("refused read returned data");
  // read data only reloads on a read setup cycle
  rdata_hold_a: assert property
    (!(psel && !penable && !pwrite) |=> $stable(prdata))
    else $error("read data moved without a read");
  dir_hold_a: assert property
    (!(psel && penable && pwrite) |=> $stable(portADirection))
    else $error("direction changed without a write");
  // ---------------------------------------------------------------
  // timing outputs
  // ---------------------------------------------------------------
  clken_hold_a: assert property
    (!(psel && penable && pwrite) |=> $stable(clockOutEn))
    else $error("clock enable changed without a write");
  clock_output_pin_duty_a: assert property
    ($rose(clockOutPin) |=> clockOutPin ##1 !clockOutPin[*2] ##1 clockOutPin)
    else $error("clock out not two high of four");
  entry_spacing_a: assert property (vectorEntry |=> !vectorEntry[*8])
    else $error("handler entry pulses too close");
  wdt_pulse_a: assert property (wdtTimeout |=> !wdtTimeout[*8])
    else $error("watchdog timeout pulses too close");
  irq_reset_a: assert property ($rose(rst_n) |-> !irq)
    else $error("interrupt high right after reset");
  cover property (vectorEntry);
  cover property (wdtTimeout);
  cover property (pslverr);
endmodule

bind tpa_top tpa_props #(.WDT_BASE_CYC(WDT_BASE_CYC)) props (
  .clock(clock), .rst_n(rst_n), .psel(psel), .penable(penable),
  .pwrite(pwrite), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .clockOutPin(clockOutPin), .clockOutEn(clockOutEn),
  .portADirection(portADirection), .vectorEntry(vectorEntry),
  .wdtTimeout(wdtTimeout), .irq(irq)
);

// file: bench/tb.sv
// self-checking bench for the timer/prescaler top, driven over APB
// assumes package, carrier and design compiled first; short watchdog base
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import tpa_pkg::*;
  logic clock = 1'h0;
  logic rst_n = 1'h0;
  logic psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rdv;
  logic pready, pslverr, lastErr, clockOutPin, clockOutEn;
  logic extIntEvent = 1'h0, portChangeEvent = 1'h0, extClockIn = 1'h0;
  logic vectorEntry, wdtTimeout, irq;
  logic [4:0] portADirection;
  int errTotal = 0, checksDone = 0, n;

  tpa_top #(.WDT_BASE_CYC(4)) dut (
    .clock(clock), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .extClockIn(extClockIn),
    .extIntEvent(extIntEvent), .portChangeEvent(portChangeEvent),
    .clockOutPin(clockOutPin), .clockOutEn(clockOutEn),
    .portADirection(portADirection), .vectorEntry(vectorEntry),
    .wdtTimeout(wdtTimeout), .irq(irq)
  );

  initial begin
    forever #12.5 clock = ~clock;
  end
  // ---------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp,
                     input string msg);
    checksDone++;
    if (seen !== exp) begin
      errTotal++;
      $display("MISMATCH %0t %s seen %h exp %h", $time, msg, seen, exp);
    end
  endtask
  // request held until pready is sampled high at a rising edge
  task automatic apb(input logic wr, input logic [9:0] idx,
                     input logic [31:0] wd);
    @(posedge clock);
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= wr;
    paddr <= {idx, 2'h0};
    pwdata <= wd;
    @(posedge clock);
    penable <= 1'h1;
    do begin
      @(posedge clock);
    end while (pready !== 1'h1);
    rdv = prdata;
    lastErr = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  task automatic wr(input logic [9:0] idx, input logic [31:0] d);
    apb(1'h1, idx, d);
  endtask
  task automatic rdc(input logic [9:0] idx, input logic [31:0] exp);
    apb(1'h0, idx, 32'h0);
    chk(rdv, exp, "register read");
  endtask
  task automatic wrapUp;
    $display("checks %0d mismatches %0d", checksDone, errTotal);
    if (errTotal == 0 && checksDone > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // ---------------------------------------------------------------
  // sequence
  // ---------------------------------------------------------------
  initial begin
    repeat (4) @(posedge clock);
    rst_n <= 1'h1;
    rdc(IDX_TIMER_PORT_CONFIG, 32'hFF);
    rdc(IDX_INTERRUPT_CONTROL, 32'h0);
    rdc(IDX_PORT_A_DIRECTION, 32'h1F);
    wr(IDX_PORT_A_DIRECTION, 32'hFFFFFFFF);
    rdc(IDX_PORT_A_DIRECTION, 32'h1F);
    chk({27'h0, portADirection}, 32'h1F, "direction pins");
    wr(IDX_INTERRUPT_CONTROL_ALT, 32'h7F);
    rdc(IDX_INTERRUPT_CONTROL, 32'h3F);
    wr(IDX_INTERRUPT_CONTROL, 32'h0);
    apb(1'h0, 10'h0FF, 32'h0);
    chk({31'h0, lastErr}, 32'h1, "unmapped error");
    chk(rdv, 32'h0, "unmapped data");
    // events flag with every enable off
    @(posedge clock);
    extIntEvent <= 1'h1;
    portChangeEvent <= 1'h1;
    @(posedge clock);
    extIntEvent <= 1'h0;
    portChangeEvent <= 1'h0;
    rdc(IDX_INTERRUPT_CONTROL, 32'h03);
    wr(IDX_INTERRUPT_CONTROL, 32'h0);
    for (int m = 0; m < 4; m++) begin
      wr(IDX_WDT_CONTROL, 32'(m) << WC_OSC_LSB);
      @(negedge clock);
      chk({31'h0, clockOutEn}, {31'h0, m == 3}, "clock out enable");
    end
    // watchdog owns prescaler at rate 0: timer steps every tick
    wr(IDX_TIMER_PORT_CONFIG, 32'h08);
    wr(IDX_IRQ_STATUS, 32'h7);
    wr(IDX_TIMER_COUNT, 32'hF0);
    repeat (80) @(posedge clock);
    chk({31'h0, irq}, 32'h0, "masked irq");
    rdc(IDX_IRQ_STATUS, 32'h1);
    rdc(IDX_INTERRUPT_CONTROL, 32'h04);
    wr(IDX_IRQ_MASK, 32'h1);
    @(negedge clock);
    chk({31'h0, irq}, 32'h1, "unmasked irq");
    wr(IDX_IRQ_STATUS, 32'h1);
    @(negedge clock);
    chk({31'h0, irq}, 32'h0, "cleared irq");
    // handler entry latency from the sampling cycle
    wr(IDX_INTERRUPT_CONTROL, 32'h20);
    wr(IDX_INTERRUPT_CONTROL, 32'hA0);
    wr(IDX_TIMER_COUNT, 32'hFC);
    n = 0;
    while (irq !== 1'h1 && n < 200) begin
      @(posedge clock);
      n++;
    end
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (vectorEntry !== 1'h1 && n < 40);
    chk(32'(n), 32'h10, "entry latency");
    rdc(IDX_INTERRUPT_CONTROL, 32'h24);
    rdc(IDX_IRQ_STATUS, 32'h5);
    // back to the timer: watchdog clear first
    wr(IDX_WDT_CONTROL, 32'h1);
    wr(IDX_TIMER_PORT_CONFIG, 32'h07);
    repeat (40) @(posedge clock);
    apb(1'h0, IDX_WDT_STATE, 32'h0);
    chk({31'h0, rdv[15:8] != 8'h00}, 32'h1, "prescaler runs");
    wr(IDX_TIMER_COUNT, 32'h0);
    apb(1'h0, IDX_WDT_STATE, 32'h0);
    chk({31'h0, rdv[15:8] < 8'h02}, 32'h1, "prescaler cleared");
    rdc(IDX_TIMER_COUNT, 32'h0);
    // timer to watchdog with the extra step for rate 000
    wr(IDX_WDT_CONTROL, 32'h3);
    wr(IDX_TIMER_COUNT, 32'h0);
    wr(IDX_TIMER_PORT_CONFIG, 32'h2F);
    wr(IDX_WDT_CONTROL, 32'h3);
    wr(IDX_TIMER_PORT_CONFIG, 32'h28);
    rdc(IDX_TIMER_PORT_CONFIG, 32'h28);
    repeat (40) @(posedge clock);
    apb(1'h0, IDX_WDT_STATE, 32'h0);
    chk({31'h0, rdv[7:0] != 8'h00}, 32'h1, "watchdog runs");
    wr(IDX_WDT_CONTROL, 32'h3);
    apb(1'h0, IDX_WDT_STATE, 32'h0);
    chk({31'h0, rdv[15:0] < 16'h0202 && rdv[7:0] < 8'h02}, 32'h1,
        "watchdog cleared");
    n = 0;
    while (wdtTimeout !== 1'h1 && n < 1500) begin
      @(posedge clock);
      n++;
    end
    chk({31'h0, n < 1500}, 32'h1, "watchdog timeout");
    apb(1'h0, IDX_IRQ_STATUS, 32'h0);
    chk(rdv & 32'h2, 32'h2, "timeout status");
    // external source, 1:1 while the watchdog owns the prescaler
    wr(IDX_TIMER_COUNT, 32'h0);
    repeat (3) begin
      @(posedge clock);
      extClockIn <= 1'h1;
      @(posedge clock);
      extClockIn <= 1'h0;
    end
    rdc(IDX_TIMER_COUNT, 32'h3);
    // falling edge select: only the falls count
    wr(IDX_TIMER_PORT_CONFIG, 32'h38);
    repeat (2) begin
      @(posedge clock);
      extClockIn <= 1'h1;
      @(posedge clock);
      extClockIn <= 1'h0;
    end
    rdc(IDX_TIMER_COUNT, 32'h5);
    wr(IDX_WDT_CONTROL, 32'h1);
    wr(IDX_TIMER_PORT_CONFIG, 32'h0);
    rdc(IDX_TIMER_PORT_CONFIG, 32'h0);
    wrapUp();
  end

  initial begin
    #250000;
    errTotal++;
    wrapUp();
  end
endmodule
